/* File: core/tkm_module.sv */
module tkm_module
    import tkm_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [3:0] key_osc_i,
    input wire logic ref_osc_i,
    input wire logic slot0_overflow_i,
    input wire logic [2:0] hw_freq_code_i,
    output logic [1:0] key_select_o,
    output logic multi_freq_enable_o,
    output logic filter_enable_o,
    output logic [2:0] osc_freq_code_o,
    output logic ref_osc_run_o,
    output logic key_osc_run_o,
    output logic [3:0] pin_touch_o,
    output logic [9:0] ref_cap_code_o,
    output logic slot_overflow_flag_o,
    output logic counting_o
);
    typedef struct packed {
        tkm_state_type state;
        logic [7:0] ctrl_first;
        logic [7:0] ctrl_second;
        logic [7:0] cap_low;
        logic [1:0] cap_high;
        logic sense_start;
        logic shared_slot_select;
        logic slot_overflow_flag;
        logic [15:0] shared_count;
        logic [15:0] module_count;
        logic [4:0] slot_count;
        logic [1:0] div_count;
        logic ref_prev;
        logic [3:0] key_prev;
        logic [7:0] rdata;
        logic [2:0] freq_code;
        logic ref_run;
        logic key_run;
        logic counting;
    } tkm_st_type;

    tkm_st_type st_reg;
    tkm_st_type st_next;

    logic running;
    logic div_tick;
    logic ref_tick;
    logic slot_tick;
    logic own_ovf;
    logic overflow;
    logic key_edge;
    logic [3:0] key_edges;

    always_comb
    begin
        st_next = st_reg;
        running = (st_reg.state == TKM_RUN);
        div_tick = (st_reg.div_count == TKM_DIV_LAST);
        ref_tick = ref_osc_i & ~st_reg.ref_prev;
        key_edges = key_osc_i & ~st_reg.key_prev;
        key_edge = key_edges[st_reg.ctrl_first[TKM_SEL_POS +: 2]];
        slot_tick = st_reg.ctrl_second[TKM_SLOTCLK_POS] ? div_tick : ref_tick;
        own_ovf = running && slot_tick && (st_reg.slot_count == TKM_SLOT_LAST);
        overflow = running && (st_reg.shared_slot_select ? slot0_overflow_i : own_ovf);
        st_next.ref_prev = ref_osc_i;
        st_next.key_prev = key_osc_i;
        st_next.div_count = st_reg.div_count + 2'd1;
        st_next.rdata = TKM_UNUSED_BYTE;
        if (rd_i)
        begin
            unique case (addr_i)
                TKM_ADDR_SHARED_HIGH: st_next.rdata = st_reg.shared_count[15:8];
                TKM_ADDR_COUNT_LOW: st_next.rdata = st_reg.module_count[7:0];
                TKM_ADDR_COUNT_HIGH: st_next.rdata = st_reg.module_count[15:8];
                TKM_ADDR_CAP_LOW: st_next.rdata = st_reg.cap_low;
                TKM_ADDR_CAP_HIGH: st_next.rdata = {6'h00, st_reg.cap_high};
                TKM_ADDR_CTRL_FIRST: st_next.rdata = st_reg.ctrl_first;
                TKM_ADDR_CTRL_SECOND: st_next.rdata = {st_reg.ctrl_second[7], 1'b0,
                    st_reg.ctrl_second[5:0]};
                TKM_ADDR_START_CTRL: st_next.rdata = {5'h00, st_reg.slot_overflow_flag,
                    st_reg.shared_slot_select, st_reg.sense_start};
            endcase
        end
        if (wr_i)
        begin
            unique case (addr_i)
                TKM_ADDR_CAP_LOW: st_next.cap_low = wdata_i;
                TKM_ADDR_CAP_HIGH: st_next.cap_high = wdata_i[1:0];
                TKM_ADDR_CTRL_FIRST: st_next.ctrl_first = wdata_i;
                TKM_ADDR_CTRL_SECOND: st_next.ctrl_second = {wdata_i[7], 1'b0, wdata_i[5:0]};
                TKM_ADDR_START_CTRL:
                begin
                    st_next.sense_start = wdata_i[TKM_START_POS];
                    st_next.shared_slot_select = wdata_i[TKM_SHSEL_POS];
                    if (!wdata_i[TKM_OVF_POS])
                    begin
                        st_next.slot_overflow_flag = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end
        // Sequencer
        unique case (st_reg.state)
            TKM_IDLE:
            begin
                if (st_next.sense_start && !st_reg.sense_start)
                begin
                    st_next.state = TKM_RUN;
                    st_next.shared_count = TKM_COUNT_RESET;
                    st_next.module_count = TKM_COUNT_RESET;
                    st_next.slot_count = TKM_SLOT_RESET;
                end
            end
            TKM_RUN:
            begin
                st_next.shared_count = st_reg.shared_count + 16'd1;
                if (key_edge && st_reg.ctrl_second[TKM_KEYEN_POS])
                begin
                    st_next.module_count = st_reg.module_count + 16'd1;
                end
                if (slot_tick)
                begin
                    st_next.slot_count = st_reg.slot_count + 5'd1;
                end
                if (overflow)
                begin
                    st_next.state = TKM_DONE;
                    st_next.slot_overflow_flag = 1'b1;
                end
            end
            TKM_DONE:
            begin
                if (!st_next.sense_start)
                begin
                    st_next.state = TKM_IDLE;
                end
            end
        endcase
        if (!st_next.sense_start)
        begin
            st_next.state = TKM_IDLE;
            st_next.shared_count = TKM_COUNT_RESET;
            st_next.module_count = TKM_COUNT_RESET;
            st_next.slot_count = TKM_SLOT_RESET;
        end
        // Hardware hopping copies hw_freq_code_i on every clock
        if (st_reg.ctrl_first[TKM_HOP_POS])
        begin
            st_next.freq_code = hw_freq_code_i;
        end
        else
        begin
            st_next.freq_code = st_reg.ctrl_first[2:0];
        end
        st_next.ref_run = (st_next.state == TKM_RUN) && st_reg.ctrl_second[TKM_REFEN_POS];
        st_next.key_run = (st_next.state == TKM_RUN) && st_reg.ctrl_second[TKM_KEYEN_POS];
        st_next.counting = (st_next.state == TKM_RUN);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st_reg <= '{state: TKM_IDLE, ctrl_first: TKM_REG_RESET,
                ctrl_second: TKM_REG_RESET, cap_low: TKM_REG_RESET,
                cap_high: TKM_CAP_HIGH_RESET, sense_start: 1'b0,
                shared_slot_select: 1'b0, slot_overflow_flag: 1'b0,
                shared_count: TKM_COUNT_RESET, module_count: TKM_COUNT_RESET,
                slot_count: TKM_SLOT_RESET, div_count: 2'h0, ref_prev: 1'b0,
                key_prev: 4'h0, rdata: TKM_REG_RESET, freq_code: 3'h0,
                ref_run: 1'b0, key_run: 1'b0, counting: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;
    assign key_select_o = st_reg.ctrl_first[TKM_SEL_POS +: 2];
    assign multi_freq_enable_o = st_reg.ctrl_first[TKM_MFREQ_POS];
    assign filter_enable_o = st_reg.ctrl_first[TKM_FILT_POS];
    assign osc_freq_code_o = st_reg.freq_code;
    assign ref_osc_run_o = st_reg.ref_run;
    assign key_osc_run_o = st_reg.key_run;
    assign pin_touch_o = st_reg.ctrl_second[3:0];
    assign ref_cap_code_o = {st_reg.cap_high, st_reg.cap_low};
    assign slot_overflow_flag_o = st_reg.slot_overflow_flag;
    assign counting_o = st_reg.counting;
endmodule

/* File: core/tkm_pkg.sv */
// Functional notes
// - Shared counter high byte, read-only, resets zero
// - Module counter readable as low/high bytes
// - Ten-bit reference capacitor code split low/high
// - High capacitor register upper six bits read zero
// - Key select bits pick one of four keys
// - Bit five of control0 enables multi-frequency
// - Bit four of control0 enables filter
// - Hopping source chooses software or hardware code
// - Software code selects eight oscillator frequencies
// - Slot clock: reference oscillator or system/4
// - Control1 bit five enables reference oscillator
// - Control1 bit four enables key oscillators
// - Control1 bits three-zero choose touch or I/O
// - Start rising edge switches counters and oscillators on
// - Slot overflow sets flag, stops oscillators, counters
package tkm_pkg;
    localparam logic [2:0] TKM_ADDR_SHARED_HIGH = 3'h0;
    localparam logic [2:0] TKM_ADDR_COUNT_LOW = 3'h1;
    localparam logic [2:0] TKM_ADDR_COUNT_HIGH = 3'h2;
    localparam logic [2:0] TKM_ADDR_CAP_LOW = 3'h3;
    localparam logic [2:0] TKM_ADDR_CAP_HIGH = 3'h4;
    localparam logic [2:0] TKM_ADDR_CTRL_FIRST = 3'h5;
    localparam logic [2:0] TKM_ADDR_CTRL_SECOND = 3'h6;
    localparam logic [2:0] TKM_ADDR_START_CTRL = 3'h7;
    localparam int TKM_SEL_POS = 6;
    localparam int TKM_MFREQ_POS = 5;
    localparam int TKM_FILT_POS = 4;
    localparam int TKM_HOP_POS = 3;
    localparam int TKM_SLOTCLK_POS = 7;
    localparam int TKM_REFEN_POS = 5;
    localparam int TKM_KEYEN_POS = 4;
    localparam int TKM_START_POS = 0;
    localparam int TKM_SHSEL_POS = 1;
    localparam int TKM_OVF_POS = 2;
    localparam logic [7:0] TKM_REG_RESET = 8'h00;
    localparam logic [1:0] TKM_CAP_HIGH_RESET = 2'h0;
    localparam logic [15:0] TKM_COUNT_RESET = 16'h0000;
    localparam logic [4:0] TKM_SLOT_RESET = 5'h00;
    localparam logic [4:0] TKM_SLOT_LAST = 5'h1f;
    localparam logic [1:0] TKM_DIV_LAST = 2'h3;
    localparam logic [7:0] TKM_UNUSED_BYTE = 8'h00;
    typedef enum {TKM_IDLE, TKM_RUN, TKM_DONE} tkm_state_type;
endpackage

/* File: sim/tkm_module_properties.sv */
module tkm_props
    import tkm_pkg::*;
(
    input wire logic clk_i, sys_rst_i, wr_i, rd_i, multi_freq_enable_o, filter_enable_o,
    input wire logic slot_overflow_flag_o, counting_o, ref_osc_run_o, key_osc_run_o,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i, rdata_o,
    input wire logic [1:0] key_select_o,
    input wire logic [3:0] pin_touch_o,
    input wire logic [9:0] ref_cap_code_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_rdq; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_rdq: assert property (p_rdq) else $error("read data not idle");
    property p_capl; wr_i && addr_i == TKM_ADDR_CAP_LOW |=> ref_cap_code_o[7:0] == $past(wdata_i);
    endproperty
    a_capl: assert property (p_capl) else $error("cap low not stored");
    property p_caph; wr_i && addr_i == TKM_ADDR_CAP_HIGH
        |=> ref_cap_code_o[9:8] == $past(wdata_i[1:0]); endproperty
    a_caph: assert property (p_caph) else $error("cap high not stored");
    property p_hz; rd_i && addr_i == TKM_ADDR_CAP_HIGH |=> rdata_o[7:2] == 6'h00; endproperty
    a_hz: assert property (p_hz) else $error("cap high upper bits set");
    property p_rcap; rd_i && addr_i == TKM_ADDR_CAP_LOW |=> rdata_o == ref_cap_code_o[7:0];
    endproperty
    a_rcap: assert property (p_rcap) else $error("cap low read wrong");
    property p_sel; wr_i && addr_i == TKM_ADDR_CTRL_FIRST |=> key_select_o == $past(wdata_i[7:6]);
    endproperty
    a_sel: assert property (p_sel) else $error("key select wrong");
    property p_flg; wr_i && addr_i == TKM_ADDR_CTRL_FIRST
        |=> {multi_freq_enable_o, filter_enable_o} == $past(wdata_i[5:4]); endproperty
    a_flg: assert property (p_flg) else $error("enables wrong");
    property p_pin; wr_i && addr_i == TKM_ADDR_CTRL_SECOND |=> pin_touch_o == $past(wdata_i[3:0]);
    endproperty
    a_pin: assert property (p_pin) else $error("pin function wrong");
    property p_stop; $rose(slot_overflow_flag_o) |-> !counting_o && !ref_osc_run_o && !key_osc_run_o;
    endproperty
    a_stop: assert property (p_stop) else $error("not stopped on overflow");
    c_ovf: cover property ($rose(slot_overflow_flag_o));
    c_run: cover property ($rose(counting_o));
    c_sel: cover property (key_select_o == 2'h3);
endmodule
bind tkm_module tkm_props u_props (.*);

/* File: sim/tkm_pads.sv */
module tkm_pads
(
    input wire logic clk_i,
    input wire logic key_run_i,
    input wire logic ref_run_i,
    output logic [3:0] key_osc_o = 4'h0,
    output logic ref_osc_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] phase_reg = 8'h00;
    always @(posedge clk_i)
    begin
        phase_reg <= phase_reg + 8'h01;
        key_osc_o <= key_run_i ? phase_reg[4:1] : 4'h0;
        ref_osc_o <= ref_run_i & phase_reg[2];
    end
endmodule

/* File: sim/touch_key_module_config_tb.sv */
module touch_key_module_config_tb
    import tkm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, mfe, fle, rrun, krun, flag, on;
    logic [2:0] addr_i = 3'h0, hw = 3'h5, fc;
    logic ovf0 = 1'b0;
    logic [7:0] wdata_i = 8'h00, rdata_o;
    logic [7:0] exp_t [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h03, 8'hff, 8'hbf};
    logic [1:0] ks;
    logic [3:0] ko, pins;
    logic ro;
    logic [9:0] cap;
    logic [15:0] q, c0, c2;
    int error_cnt = 0, checks = 0;
    always #20 clk_i = ~clk_i;
    tkm_module dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .key_osc_i(ko), .ref_osc_i(ro),
        .slot0_overflow_i(ovf0), .hw_freq_code_i(hw), .key_select_o(ks),
        .multi_freq_enable_o(mfe), .filter_enable_o(fle), .osc_freq_code_o(fc),
        .ref_osc_run_o(rrun), .key_osc_run_o(krun), .pin_touch_o(pins), .ref_cap_code_o(cap),
        .slot_overflow_flag_o(flag), .counting_o(on));
    tkm_pads pads (.clk_i(clk_i), .key_run_i(krun), .ref_run_i(rrun), .key_osc_o(ko),
        .ref_osc_o(ro));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 q = {8'h00, rdata_o};
    endtask
    task automatic meas(input logic [1:0] s, output logic [15:0] c);
        wr(TKM_ADDR_CTRL_FIRST, {s, 6'h00});
        wr(TKM_ADDR_START_CTRL, 8'h00);
        wr(TKM_ADDR_START_CTRL, 8'h01);
        @(posedge clk_i);
        #1 chk("running", {on, rrun, krun}, 16'h0007);
        for (int n = 0; n < 400 && flag !== 1'b1; n++)
        begin
            @(posedge clk_i);
            #1;
        end
        #1 chk("stopped", {flag, on, rrun, krun}, 16'h0008);
        rd(TKM_ADDR_COUNT_LOW);
        c[7:0] = q[7:0];
        rd(TKM_ADDR_COUNT_HIGH);
        c[15:8] = q[7:0];
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        finish_test();
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 0; a < 7; a++)
        begin
            rd(3'(a));
            chk("reset value", q, 16'h0000);
        end
        for (int a = 0; a < 7; a++)
            wr(3'(a), 8'hff);
        for (int a = 0; a < 7; a++)
        begin
            rd(3'(a));
            chk("readback", q, {8'h00, exp_t[a]});
        end
        chk("pins and cap", {pins, 2'h0, cap}, 16'hf3ff);
        for (int i = 0; i < 8; i++)
        begin
            wr(TKM_ADDR_CTRL_FIRST, {i[1:0], i[0], i[1], 1'b0, i[2:0]});
            repeat (2) @(posedge clk_i);
            #1 chk("control", {ks, mfe, fle, fc}, {i[1:0], i[0], i[1], i[2:0]});
        end
        wr(TKM_ADDR_CTRL_FIRST, 8'h0a);
        repeat (3) @(posedge clk_i);
        #1 chk("hw code", fc, 16'h0005);
        wr(TKM_ADDR_CTRL_SECOND, 8'hb1);
        meas(2'h2, c2);
        meas(2'h0, c0);
        chk("key count order", 16'(c0 > c2 && c2 != 16'h0000), 16'h0001);
        rd(TKM_ADDR_SHARED_HIGH);
        chk("shared high", q, 16'h0000);
        rd(TKM_ADDR_START_CTRL);
        chk("flag set", q, 16'h0005);
        wr(TKM_ADDR_START_CTRL, 8'h00);
        rd(TKM_ADDR_START_CTRL);
        chk("flag clear", q, 16'h0000);
        wr(TKM_ADDR_CTRL_SECOND, 8'h31);
        meas(2'h0, c2);
        chk("ref slot clock", 16'(c2 > c0), 16'h0001);
        wr(TKM_ADDR_START_CTRL, 8'h00);
        wr(TKM_ADDR_START_CTRL, 8'h03);
        repeat (5) @(posedge clk_i);
        ovf0 <= 1'b1;
        @(posedge clk_i);
        ovf0 <= 1'b0;
        #1 chk("shared slot stop", {flag, on}, 16'h0002);
        finish_test();
    end
endmodule
